// File: verilog/sp_port.sv
`timescale 1ns/1ns
// ==========================================================================
// Full-duplex serial port, master or slave, behind four registers.
// Contract
// - Full-duplex shifting in master or slave role.
// - Master has one slave-select output.
// - Master drives data out and serial clock.
// - Slave drives data in reverse, takes clock.
// - Port request shares vector with external interrupt.
// - Done flag sets, clears on start or reads.
// - Collision flag on busy write, clears later.
// - Early deselect error, cleared by disabling.
// - Mode fault on select conflict, clears.
// - Enable bit; low status bits read zero.
// - Select disable ignores select in phase 1, hides fault.
// - Phase bit picks sampling edge.
// - Rate code divides clock; seven stops it.
// - Data write loads shift register directly.
// - Data read returns receive buffer.
// - Select output follows select register bit.
module sp_port
(
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       ext_int2_i,
  output logic            shared_irq_vector_o,
  input  wire logic       sclk_i,
  output logic            sclk_o,
  output logic            sclk_oe_o,
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe_o,
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe_o,
  input  wire logic       slave_sel_n_i,
  output logic            master_select_out_o
);

  // ========================================================================
  // Registers and state.
  sp_pkg::sp_state_t state_r;
  logic [7:0] ctrl_r;
  logic [7:0] sel_r;
  logic [7:0] sr_r;
  logic [3:0] hc_r;
  logic       bit_r;
  logic       sclk_r;
  logic       sclk_prev_r;
  logic       done_r;
  logic       coll_r;
  logic       serr_r;
  logic       fault_r;
  logic       done_seen_r;
  logic       coll_seen_r;
  logic       conflict_prev_r;
  logic       pend_r;
  logic       xfer_coll_r;
  logic       mosi_oe_r;
  logic       miso_oe_r;

  // ========================================================================
  // Control field decoding.
  logic       en_w;
  logic       mstr_w;
  logic       cpol_w;
  logic       cpha_w;
  logic       ssdis_w;
  logic [2:0] rate_w;
  assign en_w    = ctrl_r[sp_pkg::CT_ENABLE];
  assign mstr_w  = ctrl_r[sp_pkg::CT_MASTER];
  assign cpol_w  = ctrl_r[sp_pkg::CT_POL];
  assign cpha_w  = ctrl_r[sp_pkg::CT_PHASE];
  assign ssdis_w = ctrl_r[sp_pkg::CT_SEL_DIS];
  assign rate_w  = {ctrl_r[sp_pkg::CT_RATE_HIGH], ctrl_r[sp_pkg::CT_RATE_MID],
                    ctrl_r[sp_pkg::CT_RATE_LOW]};

  // Register bus decoding.
  logic wr_st_w;
  logic wr_ct_w;
  logic wr_dt_w;
  logic wr_se_w;
  logic rd_st_w;
  logic rd_dt_w;
  logic acc_st_w;
  logic acc_dt_w;
  assign wr_st_w  = ce_i && sfr_wr_i && (sfr_addr_i == sp_pkg::ADDR_STATUS);
  assign wr_ct_w  = ce_i && sfr_wr_i && (sfr_addr_i == sp_pkg::ADDR_CONTROL);
  assign wr_dt_w  = ce_i && sfr_wr_i && (sfr_addr_i == sp_pkg::ADDR_DATA);
  assign wr_se_w  = ce_i && sfr_wr_i && (sfr_addr_i == sp_pkg::ADDR_SELECT);
  assign rd_st_w  = ce_i && sfr_rd_i && (sfr_addr_i == sp_pkg::ADDR_STATUS);
  assign rd_dt_w  = ce_i && sfr_rd_i && (sfr_addr_i == sp_pkg::ADDR_DATA);
  assign acc_st_w = rd_st_w || wr_st_w;
  assign acc_dt_w = rd_dt_w || wr_dt_w;

  // ========================================================================
  // Edge detection for both roles.
  logic tick_w;
  logic m_lead_w;
  logic m_trail_w;
  logic s_lead_w;
  logic s_trail_w;
  logic selected_w;
  logic s_start_w;
  logic m_start_w;
  logic lead_w;
  logic trail_w;
  logic samp_w;
  logic shft_w;
  logic last_w;
  logic in_bit_w;
  logic busy_w;
  logic s_drop_w;
  logic conflict_w;
  logic rx_ready_w;
  logic rx_valid_w;
  logic [7:0] rx_data_w;

  // A low select picks the slave; ignoring it needs phase 1.
  assign selected_w = !slave_sel_n_i || (ssdis_w && cpha_w);
  assign busy_w     = (state_r == sp_pkg::SP_XFER);
  assign m_lead_w   = mstr_w && busy_w && tick_w && !hc_r[0];
  assign m_trail_w  = mstr_w && busy_w && tick_w && hc_r[0];
  assign s_lead_w   = (sclk_i != cpol_w) && (sclk_prev_r == cpol_w);
  assign s_trail_w  = (sclk_i == cpol_w) && (sclk_prev_r != cpol_w);
  assign s_start_w  = ce_i && en_w && !mstr_w && !busy_w && selected_w
                      && s_lead_w;
  assign m_start_w  = ce_i && en_w && mstr_w && !busy_w && pend_r
                      && rx_ready_w;
  assign lead_w     = ce_i && (mstr_w ? m_lead_w
                      : ((busy_w && s_lead_w) || s_start_w));
  assign trail_w    = ce_i && (mstr_w ? m_trail_w : (busy_w && s_trail_w));

  // Phase 0 samples on leading edges, phase 1 on trailing ones.
  assign samp_w   = cpha_w ? trail_w : lead_w;
  assign shft_w   = cpha_w ? (lead_w && (hc_r != 4'h0)) : trail_w;
  assign last_w   = trail_w && (hc_r == sp_pkg::LAST_HALF);
  assign in_bit_w = mstr_w ? miso_i : mosi_i;
  assign s_drop_w = ce_i && en_w && !mstr_w && busy_w && !selected_w;

  // A master that sees its select pulled low is in conflict.
  assign conflict_w = en_w && mstr_w && !ssdis_w && !slave_sel_n_i;

  // ========================================================================
  // Master half-period ticks.
  sp_rate_gen u_rate
  (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .run_i     (mstr_w && busy_w),
    .rate_i    (rate_w),
    .tick_o    (tick_w)
  );

  // Received bytes queue here until software reads the data register.
  sp_rx_fifo
  #(
    .WIDTH (8),
    .DEPTH (sp_pkg::RX_DEPTH)
  )
  u_rx
  (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .in_valid_i  (last_w),
    .in_ready_o  (rx_ready_w),
    .in_data_i   (cpha_w ? {sr_r[6:0], in_bit_w} : {sr_r[6:0], bit_r}),
    .out_valid_o (rx_valid_w),
    .out_ready_i (rd_dt_w),
    .out_data_o  (rx_data_w)
  );

  // ========================================================================
  // Transfer sequencer and shift register.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      state_r <= sp_pkg::SP_IDLE;
      hc_r    <= 4'h0;
      sr_r    <= sp_pkg::RST_DATA;
      bit_r   <= 1'b0;
      pend_r  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!en_w || s_drop_w || last_w)
      begin
        state_r <= sp_pkg::SP_IDLE;
        hc_r    <= 4'h0;
        pend_r  <= pend_r && en_w && !last_w;
      end
      else if (m_start_w || s_start_w)
        state_r <= sp_pkg::SP_XFER;
      if (en_w && !last_w && (lead_w || trail_w))
        hc_r <= hc_r + 4'h1;
      if (m_start_w)
        pend_r <= 1'b0;
      if (wr_dt_w && !busy_w)
      begin
        sr_r   <= sfr_wdata_i;
        pend_r <= mstr_w;
      end
      else if (samp_w && !(cpha_w && last_w))
        bit_r <= in_bit_w;
      if (shft_w)
        sr_r <= {sr_r[6:0], bit_r}; // Data holds across sample edges.
    end
  end

  // Serial clock: toggles on each master tick, rests at idle while no transfer runs.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      sclk_r      <= 1'b0;
      sclk_prev_r <= 1'b0;
    end
    else if (ce_i)
    begin
      sclk_prev_r <= sclk_i;
      if (mstr_w && busy_w && tick_w)
        sclk_r <= !sclk_r;
      else if (!busy_w)
        sclk_r <= cpol_w;
    end
  end

  // ========================================================================
  // Status flags; every hardware set wins over a clear in the same cycle.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      done_r          <= 1'b0;
      coll_r          <= 1'b0;
      serr_r          <= 1'b0;
      fault_r         <= 1'b0;
      done_seen_r     <= 1'b0;
      coll_seen_r     <= 1'b0;
      conflict_prev_r <= 1'b0;
      xfer_coll_r     <= 1'b0;
    end
    else if (ce_i)
    begin
      conflict_prev_r <= conflict_w;
      if (rd_st_w)
        done_seen_r <= done_r;
      else if (rd_dt_w)
        done_seen_r <= 1'b0;
      if (acc_st_w)
        coll_seen_r <= 1'b1;
      else if (acc_dt_w)
        coll_seen_r <= 1'b0;
      if (m_start_w || s_start_w)
        xfer_coll_r <= 1'b0;
      else if (wr_dt_w && busy_w)
        xfer_coll_r <= 1'b1;
      if (last_w)
        done_r <= 1'b1;
      else if (busy_w || (rd_dt_w && done_seen_r))
        done_r <= 1'b0;
      if (wr_dt_w && busy_w)
        coll_r <= 1'b1;
      else if ((last_w && !xfer_coll_r) || (acc_dt_w && coll_seen_r))
        coll_r <= 1'b0;
      if (s_drop_w)
        serr_r <= 1'b1;
      else if (!en_w)
        serr_r <= 1'b0;
      if (conflict_w && !conflict_prev_r)
        fault_r <= 1'b1;
      else if (!conflict_w || (rd_st_w && fault_r))
        fault_r <= 1'b0;
    end
  end

  // ========================================================================
  // Software registers, read answer and pin drivers.
  logic [7:0] status_w;
  logic [7:0] rmux_w;
  logic       irq_w;
  assign status_w = {done_r, coll_r, serr_r, fault_r, 4'h0};
  assign rmux_w   = (sfr_addr_i == sp_pkg::ADDR_STATUS)  ? status_w
                  : (sfr_addr_i == sp_pkg::ADDR_CONTROL) ? ctrl_r
                  : (sfr_addr_i == sp_pkg::ADDR_DATA)    ? rx_data_w
                  : (sfr_addr_i == sp_pkg::ADDR_SELECT)  ? sel_r
                  : 8'h00;
  // Mode fault raises no request while select is ignored.
  assign irq_w = done_r || (fault_r && !ssdis_w);

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      ctrl_r              <= sp_pkg::RST_CONTROL;
      sel_r               <= sp_pkg::RST_SELECT;
      sfr_rdata_o         <= 8'h00;
      shared_irq_vector_o <= 1'b0;
      mosi_oe_r           <= 1'b0;
      miso_oe_r           <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ct_w)
        ctrl_r <= sfr_wdata_i;
      if (wr_se_w)
        sel_r <= sfr_wdata_i;
      if (sfr_rd_i)
        sfr_rdata_o <= (rd_dt_w && !rx_valid_w) ? 8'h00 : rmux_w;
      shared_irq_vector_o <= irq_w || ext_int2_i;
      mosi_oe_r <= en_w && mstr_w;
      miso_oe_r <= en_w && !mstr_w && selected_w;
    end
  end

  assign sclk_o              = sclk_r;
  assign sclk_oe_o           = mosi_oe_r;
  assign mosi_o              = sr_r[7];
  assign mosi_oe_o           = mosi_oe_r;
  assign miso_o              = sr_r[7];
  assign miso_oe_o           = miso_oe_r;
  assign master_select_out_o = sel_r[0];

  // ========================================================================
  // Checks.
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  a_done_sets: assert property (ce_i && last_w |=> done_r)
    else $error("done flag not set after last edge");
  a_coll_sets: assert property (wr_dt_w && busy_w |=> coll_r)
    else $error("collision flag not set on busy write");
  a_serr_sets: assert property (s_drop_w |=> serr_r)
    else $error("slave error not set on early deselect");
  a_serr_clears: assert property (ce_i && !en_w |=> !serr_r)
    else $error("slave error survived disable");
  a_low_bits_zero: assert property (
    rd_st_w |=> sfr_rdata_o[3:0] == 4'h0)
    else $error("unused status bits not zero");
  a_sel_follow: assert property (
    wr_se_w |=> master_select_out_o == $past(sfr_wdata_i[0]))
    else $error("select output does not follow register");
  a_stop_clock: assert property (ce_i && mstr_w && busy_w
    && rate_w == sp_pkg::RATE_STOP ##1 ce_i |-> $stable(sclk_o))
    else $error("serial clock moved with rate stopped");
  a_irq_shared: assert property (
    ce_i && ext_int2_i |=> shared_irq_vector_o)
    else $error("shared vector missed external request");
  a_idle_level: assert property (ce_i && !busy_w
    ##1 ce_i && !busy_w |-> sclk_o == $past(cpol_w))
    else $error("serial clock not at idle level");

  c_master_byte: cover property (mstr_w && last_w);
  c_slave_byte:  cover property (!mstr_w && last_w);
  c_slave_drop:  cover property (s_drop_w);
  c_collision:   cover property (wr_dt_w && busy_w);
endmodule

// File: verilog/sp_pkg.sv
// ==========================================================================
// Shared constants of the serial port.
package sp_pkg;
  // ========================================================================
  // Register addresses on the special-function bus.
  localparam logic [7:0] ADDR_STATUS  = 8'he1;
  localparam logic [7:0] ADDR_CONTROL = 8'he2;
  localparam logic [7:0] ADDR_DATA    = 8'he3;
  localparam logic [7:0] ADDR_SELECT  = 8'he4;

  // ========================================================================
  // Status bit positions.
  localparam int ST_DONE  = 7;
  localparam int ST_COLL  = 6;
  localparam int ST_SERR  = 5;
  localparam int ST_FAULT = 4;

  // ========================================================================
  // Control bit positions; rate code sits in bits 7, 1 and 0.
  localparam int CT_RATE_HIGH = 7;
  localparam int CT_ENABLE    = 6;
  localparam int CT_SEL_DIS   = 5;
  localparam int CT_MASTER    = 4;
  localparam int CT_POL       = 3;
  localparam int CT_PHASE     = 2;
  localparam int CT_RATE_MID  = 1;
  localparam int CT_RATE_LOW  = 0;

  // ========================================================================
  // Reset values and timing counts.
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_DATA    = 8'h00;
  localparam logic [7:0] RST_SELECT  = 8'hff;
  localparam logic [2:0] RATE_STOP   = 3'h7;
  localparam logic [3:0] LAST_HALF   = 4'hf;
  localparam int RX_DEPTH = 2;

  // Transfer state of the shifter.
  typedef enum logic [0:0] {SP_IDLE, SP_XFER} sp_state_t;
endpackage

// File: verilog/sp_rate_gen.sv
`timescale 1ns/1ns
// ==========================================================================
// Half-period tick generator for the master serial clock.
module sp_rate_gen
(
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  input  wire logic       run_i,
  input  wire logic [2:0] rate_i,
  output logic            tick_o
);
  logic [6:0] cnt_r;
  logic [6:0] lim_w;
  logic       hit_w;

  // Half period is 2 to the rate code core cycles, so the full period
  // divides by 2 to the code plus one.
  assign lim_w = 7'((8'h01 << rate_i) - 8'h01);
  assign hit_w = run_i && (rate_i != sp_pkg::RATE_STOP) && (cnt_r == lim_w);

  // Counter restarts whenever run_i is low.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      cnt_r  <= 7'h00;
      tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_r  <= (!run_i || hit_w) ? 7'h00 : cnt_r + 7'h01;
      tick_o <= hit_w;
    end
  end
endmodule

// File: verilog/sp_rx_fifo.sv
`timescale 1ns/1ns
// ==========================================================================
// Small receive buffer with valid and ready on both sides.
module sp_rx_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push_w;
  logic             pop_w;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
  assign push_w      = ce_i && in_valid_i && in_ready_o;
  assign pop_w       = ce_i && out_ready_i && out_valid_o;

  // Pointers wrap at the depth.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push_w)
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1);
      if (pop_w)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
    end
  end

  // Storage holds no reset value.
  always_ff @(posedge ref_clk_i)
  begin
    if (push_w)
      mem_r[wp_r] <= in_data_i;
  end
endmodule

// File: tb/sp_slave_model.sv
`timescale 1ns/1ns
// ==========================================================================
// Behavioural serial slave that answers the port in master role.
module sp_slave_model
(
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       mosi_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic      [7:0] rx_o,
  output logic      [7:0] bits_o
);
  logic [7:0] sh_r;
  logic       lead;

  // Start quiet with nothing received.
  initial
  begin
    miso_o = 1'b0;
    rx_o = 8'h00;
    bits_o = 8'h00;
  end

  // Selection loads the reply; phase 0 shows its first bit at once.
  always @(negedge cs_n_i)
  begin
    sh_r = tx_i;
    bits_o = 8'h00;
    if (!cpha_i)
      miso_o = sh_r[7];
  end

  // A released line shows the inverse of its last value.
  always @(posedge cs_n_i)
    miso_o = ~miso_o;

  // Sample on the edge the phase picks, move the reply on the other.
  always @(sclk_i)
  begin
    lead = (sclk_i !== cpol_i);
    if (!cs_n_i && (lead ^ cpha_i))
    begin
      rx_o = {rx_o[6:0], mosi_i};
      bits_o = bits_o + 8'h01;
    end
    else if (!cs_n_i)
    begin
      if (!cpha_i)
        sh_r = sh_r << 1;
      miso_o = sh_r[7];
      if (cpha_i)
        sh_r = sh_r << 1;
    end
  end
endmodule

// File: tb/sp_port_tb_top.sv
`timescale 1ns/1ns
// ==========================================================================
// Self-checking bench for the serial port.
module sp_port_tb_top;
  logic       ref_clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       ext_int2 = 1'b0;
  logic       tb_sclk = 1'b0;
  logic       tb_mosi = 1'b0;
  logic       tb_sel_n = 1'b1;
  logic       cpol = 1'b0;
  logic       cpha = 1'b0;
  logic [7:0] m_tx = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic [7:0] rdata, m_rx, m_bits, half_len, st, got;
  logic [2:0] rc;
  logic       irq, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic       sel_out, m_miso, sclk_w, mosi_w, miso_w, sclk_q;
  int         n_mismatch = 0;
  int         n_checks = 0;

  // Resolve each split pin from the port's output enable alone.
  assign sclk_w = sclk_oe ? sclk_o : tb_sclk;
  assign mosi_w = mosi_oe ? mosi_o : tb_mosi;
  assign miso_w = miso_oe ? miso_o : m_miso;

  // Core clock at 250 MHz.
  initial
    forever #2 ref_clk_i = ~ref_clk_i;

  sp_port i_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(1'b1),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .ext_int2_i(ext_int2),
    .shared_irq_vector_o(irq), .sclk_i(sclk_w), .sclk_o(sclk_o),
    .sclk_oe_o(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_o(miso_oe), .slave_sel_n_i(tb_sel_n),
    .master_select_out_o(sel_out));

  sp_slave_model i_slave (
    .sclk_i(sclk_w), .cs_n_i(sel_out), .mosi_i(mosi_w), .cpol_i(cpol),
    .cpha_i(cpha), .tx_i(m_tx), .miso_o(m_miso), .rx_o(m_rx),
    .bits_o(m_bits));

  // Measure the last half period of the master serial clock.
  always @(posedge ref_clk_i)
  begin
    cnt <= (sclk_o !== sclk_q) ? 8'h00 : cnt + 8'h01;
    if (sclk_o !== sclk_q)
      half_len <= cnt + 8'h01;
    sclk_q <= sclk_o;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge ref_clk_i);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    @(negedge ref_clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge ref_clk_i);
    rd = 1'b0;
    @(negedge ref_clk_i);
    st = rdata;
    if (what != "")
      check(what, rdata, exp);
  endtask

  task automatic wait_done;
    st = 8'h00;
    for (int i = 0; i < 600 && st[7] !== 1'b1; i++)
      rd_chk("", sp_pkg::ADDR_STATUS, 8'h00);
  endtask

  // Act as an external master: half period of four core cycles.
  task automatic ext_byte(input logic [7:0] b, input int n);
    got = 8'h00;
    @(negedge ref_clk_i);
    tb_sel_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      if (!cpha)
        tb_mosi = b[7-i];
      repeat (4) @(negedge ref_clk_i);
      if (!cpha)
        got = {got[6:0], miso_w};
      tb_sclk = 1'b1;
      if (cpha)
        tb_mosi = b[7-i];
      repeat (4) @(negedge ref_clk_i);
      if (cpha)
        got = {got[6:0], miso_w};
      tb_sclk = 1'b0;
    end
    repeat (4) @(negedge ref_clk_i);
    tb_sel_n = 1'b1;
    tb_mosi = ~tb_mosi;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cut a hang short well after the tests should have ended.
  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    n_mismatch++;
    close_out();
  end

  // Main sequence of tests.
  initial
  begin
    repeat (10) @(negedge ref_clk_i);
    reset_i = 1'b0;
    rd_chk("status", sp_pkg::ADDR_STATUS, 8'h00);
    rd_chk("control", sp_pkg::ADDR_CONTROL, 8'h00);
    rd_chk("data", sp_pkg::ADDR_DATA, 8'h00);
    rd_chk("select", sp_pkg::ADDR_SELECT, 8'hff);
    rd_chk("unmapped", 8'he0, 8'h00);
    check("select pin", {7'h00, sel_out}, 8'h01);
    sfr_wr(sp_pkg::ADDR_STATUS, 8'hff);
    rd_chk("status write", sp_pkg::ADDR_STATUS, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 7; k++)
    begin
      rc = 3'(k);
      cpol = rc[1];
      cpha = rc[0];
      m_tx = 8'h3c ^ {5'h00, rc};
      sfr_wr(sp_pkg::ADDR_SELECT, 8'hff);
      sfr_wr(sp_pkg::ADDR_CONTROL, {rc[2], 3'b101, rc[1], rc[0], rc[1:0]});
      sfr_wr(sp_pkg::ADDR_SELECT, 8'hfe);
      check("select low", {7'h00, sel_out}, 8'h00);
      check("master oe", {5'h00, sclk_oe, mosi_oe, miso_oe},
            8'h06);
      sfr_wr(sp_pkg::ADDR_DATA, 8'ha5 ^ {5'h00, rc});
      if (k == 0)
      begin
        repeat (4) @(negedge ref_clk_i);
        sfr_wr(sp_pkg::ADDR_DATA, 8'h11);
        rd_chk("collision", sp_pkg::ADDR_STATUS, 8'h40);
      end
      wait_done();
      check("done", st, (k == 0) ? 8'hc0 : 8'h80);
      check("irq done", {7'h00, irq}, 8'h01);
      check("half period", half_len, 8'h01 << rc);
      check("idle", {7'h00, sclk_o}, {7'h00, cpol});
      check("sent", m_rx, 8'ha5 ^ {5'h00, rc});
      check("bits", m_bits, 8'h08);
      rd_chk("received", sp_pkg::ADDR_DATA, m_tx);
      rd_chk("cleared", sp_pkg::ADDR_STATUS, 8'h00);
    end
    $display("test master rates done");
    cpol = 1'b1;
    sfr_wr(sp_pkg::ADDR_SELECT, 8'hff);
    sfr_wr(sp_pkg::ADDR_CONTROL, 8'hdb);
    sfr_wr(sp_pkg::ADDR_SELECT, 8'hfe);
    sfr_wr(sp_pkg::ADDR_DATA, 8'h77);
    repeat (100) @(negedge ref_clk_i);
    check("stopped clock", {7'h00, sclk_o}, 8'h01);
    check("no bits", m_bits, 8'h00);
    rd_chk("no done", sp_pkg::ADDR_STATUS, 8'h00);
    sfr_wr(sp_pkg::ADDR_CONTROL, 8'h00);
    sfr_wr(sp_pkg::ADDR_SELECT, 8'hff);
    $display("test stopped clock done");
    sfr_wr(sp_pkg::ADDR_CONTROL, 8'h50);
    tb_sel_n = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    check("irq fault", {7'h00, irq}, 8'h01);
    rd_chk("fault", sp_pkg::ADDR_STATUS, 8'h10);
    tb_sel_n = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    rd_chk("fault gone", sp_pkg::ADDR_STATUS, 8'h00);
    sfr_wr(sp_pkg::ADDR_CONTROL, 8'h70);
    tb_sel_n = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    check("irq ignored", {7'h00, irq}, 8'h00);
    rd_chk("no fault", sp_pkg::ADDR_STATUS, 8'h00);
    tb_sel_n = 1'b1;
    ext_int2 = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    check("irq ext", {7'h00, irq}, 8'h01);
    ext_int2 = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    check("irq low", {7'h00, irq}, 8'h00);
    $display("test faults done");
    cpol = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      cpha = p[0];
      sfr_wr(sp_pkg::ADDR_CONTROL, {5'b01000, cpha, 2'b00});
      sfr_wr(sp_pkg::ADDR_DATA, 8'h96 ^ {7'h00, cpha});
      check("slave oe", {6'h00, sclk_oe, mosi_oe}, 8'h00);
      ext_byte(8'h69 ^ {7'h00, cpha}, 8);
      check("slave out", got, 8'h96 ^ {7'h00, cpha});
      rd_chk("slave done", sp_pkg::ADDR_STATUS, 8'h80);
      rd_chk("slave in", sp_pkg::ADDR_DATA,
             8'h69 ^ {7'h00, cpha});
    end
    ext_byte(8'h00, 3);
    rd_chk("slave error", sp_pkg::ADDR_STATUS, 8'h20);
    rd_chk("error kept", sp_pkg::ADDR_STATUS, 8'h20);
    sfr_wr(sp_pkg::ADDR_CONTROL, 8'h00);
    rd_chk("error cleared", sp_pkg::ADDR_STATUS, 8'h00);
    $display("test slave done");
    close_out();
  end
endmodule
